//--- src/fsq_frame_store_seq.sv
// Frame store and refreshed frame store readout sequencer for the imaging_ccd
//
// Notes on behaviour
// - Image half integrates while store half holds previous image, read row by row.
// - End integration with 512 simultaneous row shifts of image and store sections.
// - Block transfer at 100 kHz row clock completes in about 5 ms.
// - Store readout runs while next image integrates, via one or two amplifiers.
// - Store readout takes 2.4 s on two nodes, 4.8 s on one; sets frame time.
// - Binning, node count and chip selection are settable by command.
// - Normal frame store integration time is not programmable; readout sets it.
// - Refreshed mode: after readout, long image goes to store and is rejected.
// - Then a short integration, about 50 ms, is transferred into the store.
// - Displaced rejected image is stacked into serial register, one line discarded.
// - Refreshed frame transfer at single-line rate takes 5.1 ms.
// - Short integrations are spaced by the full store readout time.
// - Refreshed frame store only allowed on central chips.
// - Event data use the same 64-bit format as full frame.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module fsq_frame_store_seq #(
  parameter int READ_TWO_CYC = fsq_pkg::READ_TWO_CYC,
  parameter int READ_ONE_CYC = fsq_pkg::READ_ONE_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic img_shift,
  output logic store_shift,
  output logic serial_read,
  output logic discard_line,
  output logic integrating,
  output logic rejected,
  output logic two_node,
  output logic [1:0] bin_mode,
  output logic [2:0] chip_sel,
  output logic [1:0] dhu_fmt
);
  // Per-row readout periods; total readout is rows times this
  localparam int ROW_TWO_CYC = READ_TWO_CYC / int'(fsq_pkg::BLOCK_ROWS);
  localparam int ROW_ONE_CYC = READ_ONE_CYC / int'(fsq_pkg::BLOCK_ROWS);

  logic rst_q1;
  logic rst_n;
  logic [7:0] ctrl;
  logic [9:0] rows;
  logic [15:0] short_ms;
  logic err;
  logic [15:0] frames;
  fsq_pkg::fsq_state_t state;
  logic [9:0] row_cnt;
  logic [31:0] tmr;
  logic line_tick;
  logic run_ok;
  logic chip_central;
  logic [31:0] row_period;
  logic [31:0] short_ticks;
  logic xfer_state;
  logic [9:0] xfer_rows;
  logic xfer_last;
  logic read_row_end;
  logic read_last;
  logic err_set;
  logic frame_done;
  logic status_clr;
  logic short_end;
  logic phase_end;

  // Reset released through two flops so every flop leaves reset together
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Line-rate enable for row shifts and short-integration timing
  fsq_tick_div #(
    .DIV(fsq_pkg::LINE_DIV)
  ) u_line_div (
    .clk(ref_clk),
    .rst_n(rst_n),
    .run(ctrl[fsq_pkg::CTRL_RUN]),
    .tick(line_tick)
  );

  // Chip selection check: frame store and refreshed only on central chips
  assign chip_central = fsq_pkg::CENTRAL_MASK[ctrl[fsq_pkg::CTRL_CHIP_LO +: 3]];
  assign run_ok = ctrl[fsq_pkg::CTRL_RUN] && chip_central;
  assign err_set = ctrl[fsq_pkg::CTRL_RUN] && !chip_central;

  // Readout row period from node choice: fewer nodes, twice the time
  assign row_period = ctrl[fsq_pkg::CTRL_TWO] ? 32'(ROW_TWO_CYC) : 32'(ROW_ONE_CYC);
  assign short_ticks = 32'(short_ms) * 32'(fsq_pkg::TICKS_PER_MS);

  // Transfer bookkeeping shared by all three transfer states
  assign xfer_state = (state == fsq_pkg::ST_XFER) || (state == fsq_pkg::ST_REJ_XFER) ||
                      (state == fsq_pkg::ST_SHORT_XFER);
  // Refreshed transfers run at single-line rate for 5.1 ms worth of lines
  assign xfer_rows = (state == fsq_pkg::ST_XFER) ? rows : fsq_pkg::REFR_XFER_ROWS;
  assign xfer_last = line_tick && (row_cnt == xfer_rows - 10'h001);
  assign read_row_end = (tmr == row_period - 32'h0000_0001);
  assign read_last = read_row_end && (row_cnt == rows - 10'h001);
  assign frame_done = (state == fsq_pkg::ST_READ) && read_last;
  assign status_clr = reg_wr && (reg_addr == fsq_pkg::REG_STATUS) &&
                      reg_wdata[fsq_pkg::STAT_ERR];
  // Short window counted in line ticks; zero ends on the first tick
  assign short_end = line_tick && (tmr + 32'h0000_0001 >= short_ticks);
  // Any phase change clears both counters so each phase starts from zero
  assign phase_end = (xfer_state && xfer_last) ||
                     ((state == fsq_pkg::ST_READ) && read_last) ||
                     ((state == fsq_pkg::ST_SHORT_INT) && short_end) ||
                     ((state == fsq_pkg::ST_DISCARD) && read_row_end);

  // Command registers: binning, node choice, chip, mode, row count, short time
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= fsq_pkg::CTRL_RST;
      rows <= fsq_pkg::BLOCK_ROWS;
      short_ms <= fsq_pkg::SHORT_INT_MS_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        fsq_pkg::REG_CTRL: ctrl <= reg_wdata[7:0];
        fsq_pkg::REG_ROWS: rows <= reg_wdata[9:0];
        // Lower bound for a 10:1 ratio is the controller's duty
        fsq_pkg::REG_SHORT: short_ms <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Sticky refusal flag; a new refusal wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      err <= 1'b0;
    end else if (err_set) begin
      err <= 1'b1;
    end else if (status_clr) begin
      err <= 1'b0;
    end
  end

  // Completed store readouts, wraps silently
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frames <= 16'h0000;
    end else if (frame_done) begin
      frames <= frames + 16'h0001;
    end
  end

  // Phase sequencing; dropping run aborts at once since the CCD state is discarded anyway
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= fsq_pkg::ST_IDLE;
    end else if (!run_ok) begin
      state <= fsq_pkg::ST_IDLE;
    end else begin
      case (state)
        fsq_pkg::ST_IDLE: begin
          state <= fsq_pkg::ST_XFER;
        end
        fsq_pkg::ST_XFER: begin
          if (xfer_last) begin
            state <= fsq_pkg::ST_READ;
          end
        end
        fsq_pkg::ST_READ: begin
          // Frame time is the readout itself, nothing to program
          if (read_last && ctrl[fsq_pkg::CTRL_REFR]) begin
            state <= fsq_pkg::ST_REJ_XFER;
          end else if (read_last) begin
            state <= fsq_pkg::ST_XFER;
          end
        end
        fsq_pkg::ST_REJ_XFER: begin
          if (xfer_last) begin
            state <= fsq_pkg::ST_SHORT_INT;
          end
        end
        fsq_pkg::ST_SHORT_INT: begin
          if (short_end) begin
            state <= fsq_pkg::ST_SHORT_XFER;
          end
        end
        fsq_pkg::ST_SHORT_XFER: begin
          if (xfer_last) begin
            state <= fsq_pkg::ST_DISCARD;
          end
        end
        fsq_pkg::ST_DISCARD: begin
          // One serial line readout flushes the stacked rejected image
          if (read_row_end) begin
            state <= fsq_pkg::ST_READ;
          end
        end
        default: begin
          state <= fsq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Row counter restarts with every phase, so a transfer length is the count alone
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_cnt <= 10'h000;
    end else if (!run_ok || phase_end || (state == fsq_pkg::ST_IDLE)) begin
      row_cnt <= 10'h000;
    end else if (xfer_state && line_tick) begin
      row_cnt <= row_cnt + 10'h001;
    end else if ((state == fsq_pkg::ST_READ) && read_row_end) begin
      row_cnt <= row_cnt + 10'h001;
    end
  end

  // Cycle timer for readout rows and for line ticks of the short window
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr <= 32'h0000_0000;
    end else if (!run_ok || phase_end) begin
      tmr <= 32'h0000_0000;
    end else if ((state == fsq_pkg::ST_READ) || (state == fsq_pkg::ST_DISCARD)) begin
      // Each readout row lasts row_period clocks
      if (read_row_end) begin
        tmr <= 32'h0000_0000;
      end else begin
        tmr <= tmr + 32'h0000_0001;
      end
    end else if ((state == fsq_pkg::ST_SHORT_INT) && line_tick) begin
      tmr <= tmr + 32'h0000_0001;
    end
  end

  // Image section moves only on line ticks of a block or refreshed transfer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      img_shift <= 1'b0;
    end else begin
      img_shift <= run_ok && xfer_state && line_tick;
    end
  end

  // Store section follows every transfer tick and steps once per readout row
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      store_shift <= 1'b0;
    end else begin
      store_shift <= run_ok && ((xfer_state && line_tick) ||
                     ((state == fsq_pkg::ST_READ) && read_row_end));
    end
  end

  // Serial register runs during readout rows and the flush line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_read <= 1'b0;
    end else begin
      serial_read <= run_ok && ((state == fsq_pkg::ST_READ) ||
                     (state == fsq_pkg::ST_DISCARD));
    end
  end

  // End of the single flush line, a pulse so the chain can count it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      discard_line <= 1'b0;
    end else begin
      discard_line <= run_ok && (state == fsq_pkg::ST_DISCARD) && read_row_end;
    end
  end

  // Image section collects during readout, and during the short window
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      integrating <= 1'b0;
    end else begin
      integrating <= run_ok && ((state == fsq_pkg::ST_READ) ||
                     (state == fsq_pkg::ST_SHORT_INT));
    end
  end

  // Rejected phase spans both refreshed transfers and the flush line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rejected <= 1'b0;
    end else begin
      rejected <= run_ok && ((state == fsq_pkg::ST_REJ_XFER) ||
                  (state == fsq_pkg::ST_SHORT_XFER) ||
                  (state == fsq_pkg::ST_DISCARD));
    end
  end

  // Node choice for the readout chain, one cycle behind the command
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      two_node <= 1'b0;
    end else begin
      two_node <= ctrl[fsq_pkg::CTRL_TWO];
    end
  end

  // Binning code for the readout chain
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bin_mode <= 2'h0;
    end else begin
      bin_mode <= ctrl[fsq_pkg::CTRL_BIN_LO +: 2];
    end
  end

  // Chip id; an outer chip is shown but never shifted, the run check refuses it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chip_sel <= 3'h0;
    end else begin
      chip_sel <= ctrl[fsq_pkg::CTRL_CHIP_LO +: 3];
    end
  end

  // Event format is fixed, so the data handling unit needs no mode switch
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dhu_fmt <= fsq_pkg::FMT_EVT64;
    end else begin
      dhu_fmt <= fsq_pkg::FMT_EVT64;
    end
  end

  // Read port: data stand the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        fsq_pkg::REG_CTRL: reg_rdata <= {24'h00_0000, ctrl};
        fsq_pkg::REG_ROWS: reg_rdata <= {22'h00_0000, rows};
        fsq_pkg::REG_SHORT: reg_rdata <= {16'h0000, short_ms};
        fsq_pkg::REG_STATUS: reg_rdata <= {16'h0000, row_cnt, 1'b0, rejected, err, state};
        fsq_pkg::REG_FRAMES: reg_rdata <= {16'h0000, frames};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule

//--- src/fsq_pkg.sv
// Constants and types shared by the frame store readout sequencer
package fsq_pkg;
  // Clocking
  localparam int CLK_HZ = 10_000_000;
  localparam int ROW_CLK_HZ = 100_000;
  localparam int LINE_DIV = CLK_HZ / ROW_CLK_HZ;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int TICKS_PER_MS = ROW_CLK_HZ / 1000;

  // Transfer geometry and timing
  localparam logic [9:0] BLOCK_ROWS = 10'h200;
  localparam int LINE_TIME_US = 10;
  localparam int REFR_XFER_TIME_US = 5100;
  localparam logic [9:0] REFR_XFER_ROWS = 10'(REFR_XFER_TIME_US / LINE_TIME_US);
  localparam int READ_TWO_MS = 2400;
  localparam int READ_ONE_MS = 4800;
  localparam int READ_TWO_CYC = READ_TWO_MS * CYC_PER_MS;
  localparam int READ_ONE_CYC = READ_ONE_MS * CYC_PER_MS;
  localparam logic [15:0] SHORT_INT_MS_RST = 16'h0032;

  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ROWS = 8'h04;
  localparam logic [7:0] REG_SHORT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_FRAMES = 8'h10;

  // Control field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_REFR = 1;
  localparam int CTRL_TWO = 2;
  localparam int CTRL_BIN_LO = 3;
  localparam int CTRL_CHIP_LO = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Status field positions
  localparam int STAT_ERR = 3;
  localparam int STAT_REJ = 4;
  localparam int STAT_ROW_LO = 6;

  // Chips allowed to run frame store (bit per chip id)
  localparam logic [7:0] CENTRAL_MASK = 8'h03;

  // Event format code handed to the data handling unit
  localparam logic [1:0] FMT_EVT64 = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_XFER,
    ST_READ,
    ST_REJ_XFER,
    ST_SHORT_INT,
    ST_SHORT_XFER,
    ST_DISCARD
  } fsq_state_t;
endpackage

//--- src/fsq_tick_div.sv
// Divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
module fsq_tick_div #(
  parameter int DIV = 100
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);
  logic [15:0] cnt;

  // Restarts whenever run drops so the first tick is a full period away
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt == 16'(DIV - 1)) begin
      cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

//--- bench/fsq_frame_store_seq_properties.sv
// Port-level assertions for the frame store readout sequencer
`timescale 1ns/1ps
module fsq_seq_props #(
  parameter int READ_TWO_CYC = 5120,
  parameter int READ_ONE_CYC = 10240
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic img_shift,
  input wire logic store_shift,
  input wire logic serial_read,
  input wire logic discard_line,
  input wire logic integrating,
  input wire logic rejected,
  input wire logic two_node,
  input wire logic [2:0] chip_sel,
  input wire logic [1:0] dhu_fmt
);
  localparam int ROW_TWO = READ_TWO_CYC / 512;
  localparam int ROW_ONE = READ_ONE_CYC / 512;
  logic [7:0] shift_gap;
  logic [15:0] row_gap;
  logic prev_row;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Gap counters saturate so a restarted run never looks too fast
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      shift_gap <= 8'hff;
      row_gap <= 16'hffff;
    end else begin
      shift_gap <= img_shift ? 8'h01 : shift_gap + 8'(shift_gap != 8'hff);
      row_gap <= store_shift ? 16'h0001 : row_gap + 16'(row_gap != 16'hffff);
    end
  end
  // Row spacing is only meaningful between two readout rows
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prev_row <= 1'b0;
    end else if (rejected || img_shift) begin
      prev_row <= 1'b0;
    end else if (store_shift) begin
      prev_row <= serial_read;
    end
  end
  sequence s_resume;
    ##[1:3] (integrating && serial_read && !rejected);
  endsequence
  a_shift_paired: assert property (img_shift |-> store_shift)
    else $error("image shift without store shift");
  a_shift_spacing: assert property (img_shift |-> shift_gap >= 8'h64)
    else $error("row shifts closer than one line period");
  a_row_period: assert property (store_shift && !img_shift && serial_read && prev_row
    |-> row_gap == 16'(two_node ? ROW_TWO : ROW_ONE))
    else $error("readout row period wrong");
  a_read_integ: assert property (serial_read && !rejected |-> integrating)
    else $error("readout without integration");
  a_shift_quiet: assert property (img_shift |-> !integrating)
    else $error("image shifted while integrating");
  a_fmt_fixed: assert property (dhu_fmt == fsq_pkg::FMT_EVT64)
    else $error("event format code changed");
  a_central_only: assert property (img_shift |-> fsq_pkg::CENTRAL_MASK[chip_sel])
    else $error("transfer on an outer chip");
  a_rej_quiet: assert property (rejected |-> !integrating)
    else $error("integrating during rejected phase");
  a_discard_resume: assert property (discard_line |-> s_resume)
    else $error("readout did not resume after discard");
endmodule
bind fsq_frame_store_seq fsq_seq_props #(.READ_TWO_CYC(READ_TWO_CYC),
  .READ_ONE_CYC(READ_ONE_CYC)) fsq_seq_props_i (.ref_clk(ref_clk), .nrst(nrst),
  .img_shift(img_shift), .store_shift(store_shift), .serial_read(serial_read),
  .discard_line(discard_line), .integrating(integrating), .rejected(rejected),
  .two_node(two_node), .chip_sel(chip_sel), .dhu_fmt(dhu_fmt));

//--- bench/fsq_ccd_model.sv
// Behavioural CCD clock and readout chain that tallies what it is told
`timescale 1ns/1ps
module fsq_ccd_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic img_shift,
  input wire logic store_shift,
  input wire logic serial_read,
  input wire logic discard_line,
  input wire logic rejected
);
  int xfer_cnt, rej_cnt, row_cnt, disc_cnt;
  // Sections move only together, rows leave the store one at a time
  always_ff @(posedge ref_clk) begin
    if (!nrst || clr) begin
      xfer_cnt <= 0;
      rej_cnt <= 0;
      row_cnt <= 0;
      disc_cnt <= 0;
    end else begin
      xfer_cnt <= xfer_cnt + int'(img_shift && store_shift && !rejected);
      rej_cnt <= rej_cnt + int'(img_shift && store_shift && rejected);
      row_cnt <= row_cnt + int'(store_shift && !img_shift && serial_read && !rejected);
      disc_cnt <= disc_cnt + int'(discard_line);
    end
  end
endmodule

//--- bench/tb_frame_store_ccd_readout_sequencer.sv
// Register-driven testbench for the frame store readout sequencer
`timescale 1ns/1ps
module tb_frame_store_ccd_readout_sequencer;
  logic ref_clk, nrst, reg_wr, reg_rd, clr;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic img_shift, store_shift, serial_read, discard_line, integrating, rejected, two_node;
  logic [1:0] bin_mode, dhu_fmt;
  logic [2:0] chip_sel;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  // Short readout so a row takes 10 or 20 clocks
  fsq_frame_store_seq #(.READ_TWO_CYC(5120), .READ_ONE_CYC(10240)) fsq_frame_store_seq_i (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .img_shift(img_shift),
    .store_shift(store_shift), .serial_read(serial_read), .discard_line(discard_line),
    .integrating(integrating), .rejected(rejected), .two_node(two_node),
    .bin_mode(bin_mode), .chip_sel(chip_sel), .dhu_fmt(dhu_fmt));
  fsq_ccd_model fsq_ccd_model_i (.ref_clk(ref_clk), .nrst(nrst), .clr(clr),
    .img_shift(img_shift), .store_shift(store_shift), .serial_read(serial_read),
    .discard_line(discard_line), .rejected(rejected));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic wrap_up;
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Two refreshed transfers of 510 lines dominate the run length
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 120000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic expect_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    check(what, rd_val, exp);
  endtask
  // Bounded wait on serial_read (0), rejected (1) or discard_line (2)
  task automatic wait_hi(input int sel, input int lim);
    int n;
    n = 0;
    while (n < lim && (sel == 0 ? serial_read : sel == 1 ? rejected : discard_line) !== 1'b1) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check("wait", 32'(n < lim), 32'h1);
  endtask
  task automatic restart(input logic [31:0] ctrl);
    reg_write(fsq_pkg::REG_CTRL, 32'h0);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    reg_write(fsq_pkg::REG_CTRL, ctrl);
  endtask
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    clr = 1'b0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    expect_reg("ctrl", fsq_pkg::REG_CTRL, 32'h0);
    expect_reg("rows", fsq_pkg::REG_ROWS, 32'h200);
    expect_reg("short", fsq_pkg::REG_SHORT, 32'h32);
    expect_reg("status", fsq_pkg::REG_STATUS, 32'h0);
    expect_reg("hole", 8'h14, 32'h0);
    check("fmt", {30'h0, dhu_fmt}, 32'h1);
    // Every binning code, chip ids 0 to 3 and both node choices reach the chain
    for (int i = 0; i < 4; i++) begin
      reg_write(fsq_pkg::REG_CTRL, 32'(i * 40 + 4 * (i % 2)));
      repeat (2) @(posedge ref_clk);
      #1 check("bin", {30'h0, bin_mode}, 32'(i));
      check("chip", {29'h0, chip_sel}, 32'(i));
      check("nodes", {31'h0, two_node}, 32'(i % 2));
    end
    // Outer chip is refused with a sticky error
    restart(32'h41);
    repeat (4) @(posedge ref_clk);
    expect_reg("refused", fsq_pkg::REG_STATUS, 32'h8);
    check("no shift", 32'(fsq_ccd_model_i.xfer_cnt), 32'h0);
    reg_write(fsq_pkg::REG_CTRL, 32'h0);
    reg_write(fsq_pkg::REG_STATUS, 32'h8);
    expect_reg("err clear", fsq_pkg::REG_STATUS, 32'h0);
    // Normal frame store, two nodes then one, four rows each
    reg_write(fsq_pkg::REG_ROWS, 32'h4);
    restart(32'h25);
    wait_hi(0, 1000);
    repeat (2) @(posedge ref_clk);
    #1 check("xfer rows", 32'(fsq_ccd_model_i.xfer_cnt), 32'h4);
    repeat (60) @(posedge ref_clk);
    #1 check("read rows", 32'(fsq_ccd_model_i.row_cnt), 32'h4);
    expect_reg("frames", fsq_pkg::REG_FRAMES, 32'h1);
    restart(32'h21);
    wait_hi(0, 1000);
    repeat (100) @(posedge ref_clk);
    #1 check("one node rows", 32'(fsq_ccd_model_i.row_cnt), 32'h4);
    expect_reg("frames 2", fsq_pkg::REG_FRAMES, 32'h2);
    // The 51 ms floor is kept as a setting; the run uses zero to stay short
    reg_write(fsq_pkg::REG_SHORT, 32'h33);
    expect_reg("short floor", fsq_pkg::REG_SHORT, 32'h33);
    // Refreshed frame store with the shortest integration
    reg_write(fsq_pkg::REG_SHORT, 32'h0);
    reg_write(fsq_pkg::REG_ROWS, 32'h2);
    restart(32'h3);
    wait_hi(1, 3000);
    check("read first", 32'(fsq_ccd_model_i.row_cnt), 32'h2);
    wait_hi(2, 105000);
    check("rej shifts", 32'(fsq_ccd_model_i.rej_cnt), 32'h3fc);
    repeat (4) @(posedge ref_clk);
    #1 check("discards", 32'(fsq_ccd_model_i.disc_cnt), 32'h1);
    check("resumed", {31'h0, integrating}, 32'h1);
    reg_write(fsq_pkg::REG_CTRL, 32'h0);
    wrap_up();
  end
endmodule
